/* src/alarm_fault_log.sv */
// Alarm pin drive/sense, temperature warning, driver shutdown and fault records, APB register file.
// Assumes a 125 MHz clock and event inputs already on this clock.
//
// Operation
// - Pull-up enable bit switches the alarm pin internal pull-up on or off.
// - Polarity bit picks low-on-error or released-on-error pin drive.
// - Polarity 0 and no internal error: outside low level is external error.
// - Three-bit code sets minimum indication time in 12.5 ms steps.
// - Temperature over warning threshold raises the warning event.
// - Warning clears only below threshold minus hysteresis.
// - Shutdown threshold forces driver shutdown regardless of masks.
// - Reactivation mode: 0 recover when errors gone, 1 stay off until power-on after a shutdown-mask event (not after temperature shutdown).
// - First and most recent logged events are kept in two records.
// - Cumulative record sets a sticky bit per logged event.
// - Each record is seven bits ordered like the logging mask.
// - Records are split across offsets 0x60 to 0x63 as mapped.
// - Event bits: config, overtemp, external, max, min, clip, loss.
// - Per-event alarm mask decides which internal events move the pin; the external event bit has no effect on it.
// - Per-event shutdown mask tristates drivers and pin, forces low range.
// - Only events in the logging mask are latched into records.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_map.svh"

module alarm_fault_log #(
	parameter int STEP_CYCLES = `MIT_STEP_US * `CLK_MHZ
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire alarm_pkg::event_vec_t event_in,
	input wire logic [7:0] temp_in,
	input wire logic alarm_pin_in,
	output logic alarm_pin_out,
	output logic alarm_pin_oe_out,
	output logic alarm_pullup_out,
	output logic driver_enable_out,
	output logic aux_low_range_out,
	output logic irq_out
);
	import alarm_pkg::*;

	// Configuration, record, status and internal state registers
	logic [7:0] alarm_pin_cfg;
	logic [7:0] alarm_mask;
	logic [7:0] shutdown_mask;
	logic [7:0] pullup_cfg;
	logic [7:0] react_cfg;
	logic [7:0] rec60;
	logic [7:0] rec61;
	logic [7:0] rec62;
	logic [7:0] rec63;
	logic [7:0] temp_warn;
	logic [7:0] temp_off;
	logic [7:0] temp_hyst;
	logic [6:0] irq_status;
	logic [6:0] irq_mask;
	logic first_done;
	logic warn_flag;
	logic drv_latched_off;
	logic [6:0] prev_events;
	logic [6:0] prev_all;
	logic [2:0] pin_sync;
	logic [2:0] oe_hist;
	pin_state_t pin_state;
	logic [2:0] steps_left;
	logic [31:0] step_cnt;

	// APB decode: index is address divided by four
	wire logic [7:0] idx = paddr_in[9:2];
	wire logic access = psel_in && penable_in;
	wire logic wr = access && pwrite_in;
	wire logic [7:0] wb = pwdata_in[7:0];
	wire logic mapped = (idx == `IDX_ALARM_PIN_CFG) || (idx == `IDX_ALARM_MASK) ||
		(idx == `IDX_SHUTDOWN_MASK) || (idx == `IDX_PULLUP_CFG) || (idx == `IDX_REACT_CFG) ||
		(idx == `IDX_FIRST_REC) || (idx == `IDX_LAST_REC_LOW) || (idx == `IDX_LAST_CUM_REC) ||
		(idx == `IDX_CUM_REC_HIGH) || (idx == `IDX_EVENT_IN) || (idx == `IDX_IRQ_STATUS) ||
		(idx == `IDX_IRQ_MASK) || (idx == `IDX_TEMP_CTRL) || (idx == `IDX_STATUS);
	wire logic addr_ok = mapped && (paddr_in[31:10] == 22'h0) && (paddr_in[1:0] == 2'b00);

	// Logging mask spans two registers
	wire logic [6:0] log_mask = {react_cfg[2:0], pullup_cfg[7:4]};

	// Temperature warning with hysteresis; shutdown threshold independent of masks
	wire logic temp_above = temp_in > temp_warn;
	wire logic temp_below = {1'b0, temp_in} < ({1'b0, temp_warn} - {1'b0, temp_hyst});
	wire logic temp_shutdown = temp_in > temp_off;

	// External error only sensed with polarity 0 and pin released by us
	wire logic polarity = alarm_pin_cfg[`POS_POLARITY];
	wire logic pin_low = !pin_sync[2] && !pin_sync[1];
	wire logic [6:0] int_events = {event_in[6], warn_flag, 1'b0, event_in[3:0]};
	wire logic int_alarm = |(int_events & alarm_mask[6:0]);
	// Our own release still shows low in the synchroniser for a few cycles, so wait those out
	wire logic own_drive_recent = alarm_pin_oe_out || (oe_hist != 3'b000);
	wire logic ext_error = !polarity && !int_alarm && pin_low && !own_drive_recent;
	wire logic [6:0] all_events = int_events | ({6'h0, ext_error} << `EV_EXTERNAL);
	wire logic alarm_active = |(all_events & alarm_mask[6:0]);
	wire logic shutdown_now = |(all_events & shutdown_mask[6:0]) || temp_shutdown;

	// Logged events rising this cycle
	wire logic [6:0] logged = all_events & log_mask;
	wire logic [6:0] new_logged = logged & ~prev_events;

	// Minimum indication time holds the error state
	wire logic indicate = (pin_state != PIN_IDLE) || (int_alarm && alarm_mask[6:0] != 7'h0);
	wire logic drv_off = shutdown_now || drv_latched_off;
	wire logic next_pin_oe = drv_off ? 1'b0 : (polarity ? !indicate : indicate);

	// Read mux
	logic [7:0] rd_byte;
	always_comb begin
		case (idx)
			`IDX_ALARM_PIN_CFG: rd_byte = alarm_pin_cfg;
			`IDX_ALARM_MASK: rd_byte = alarm_mask;
			`IDX_SHUTDOWN_MASK: rd_byte = shutdown_mask;
			`IDX_PULLUP_CFG: rd_byte = pullup_cfg;
			`IDX_REACT_CFG: rd_byte = react_cfg;
			`IDX_FIRST_REC: rd_byte = rec60;
			`IDX_LAST_REC_LOW: rd_byte = rec61;
			`IDX_LAST_CUM_REC: rd_byte = rec62;
			`IDX_CUM_REC_HIGH: rd_byte = rec63;
			`IDX_EVENT_IN: rd_byte = {1'b0, all_events};
			`IDX_IRQ_STATUS: rd_byte = {1'b0, irq_status};
			`IDX_IRQ_MASK: rd_byte = {1'b0, irq_mask};
			`IDX_TEMP_CTRL: rd_byte = temp_hyst;
			`IDX_STATUS: rd_byte = {4'h0, warn_flag, drv_off, indicate, first_done};
			default: rd_byte = 8'h00;
		endcase
	end

	// APB answer: zero wait states, error on unmapped address
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= psel_in && !penable_in && !addr_ok;
			prdata_out <= (psel_in && !penable_in && addr_ok) ? {24'h0, rd_byte} : 32'h0000_0000;
		end
	end
	wire logic wr_ok = wr && pready_out && addr_ok;

	// Configuration writes
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_pin_cfg <= `RST_BYTE;
			alarm_mask <= `RST_BYTE;
			shutdown_mask <= `RST_BYTE;
			pullup_cfg <= `RST_BYTE;
			react_cfg <= `RST_BYTE;
			irq_mask <= 7'h00;
			temp_hyst <= `RST_TEMP_HYST;
		end else if (wr_ok) begin
			case (idx)
				`IDX_ALARM_PIN_CFG: alarm_pin_cfg <= wb;
				`IDX_ALARM_MASK: alarm_mask <= wb;
				`IDX_SHUTDOWN_MASK: shutdown_mask <= wb;
				`IDX_PULLUP_CFG: pullup_cfg <= wb;
				`IDX_REACT_CFG: react_cfg <= wb;
				`IDX_IRQ_MASK: irq_mask <= wb[6:0];
				`IDX_TEMP_CTRL: temp_hyst <= wb;
				default: ;
			endcase
		end
	end

	// Thresholds are fixed limits, wider gap for shutdown
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			temp_warn <= 8'h64;
			temp_off <= 8'h78;
		end else begin
			temp_warn <= temp_warn;
			temp_off <= temp_off;
		end
	end

	// Warning flag: set above threshold, cleared only below hysteresis band
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			warn_flag <= 1'b0;
		end else if (temp_above) begin
			warn_flag <= 1'b1;
		end else if (temp_below) begin
			warn_flag <= 1'b0;
		end
	end

	// Pin input passes three flops; a low counts once stages 2 and 3 agree, a high as soon as stage 2 shows it
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_sync <= 3'b111;
			oe_hist <= 3'b000;
		end else begin
			pin_sync <= {pin_sync[1:0], alarm_pin_in};
			oe_hist <= {oe_hist[1:0], alarm_pin_oe_out};
		end
	end

	// Minimum indication: start on first assertion, release after timer and clear
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_state <= PIN_IDLE;
			steps_left <= 3'h0;
			step_cnt <= 32'h0000_0000;
		end else begin
			case (pin_state)
				PIN_IDLE: begin
					if (int_alarm) begin
						steps_left <= alarm_pin_cfg[`POS_MIT_HI:`POS_MIT_LO];
						step_cnt <= 32'h0000_0000;
						pin_state <= PIN_HOLD;
					end
				end
				PIN_HOLD: begin
					if (steps_left == 3'h0) begin
						pin_state <= PIN_WAIT_CLEAR;
					end else if (step_cnt == 32'(STEP_CYCLES - 1)) begin
						step_cnt <= 32'h0000_0000;
						steps_left <= steps_left - 3'h1;
					end else begin
						step_cnt <= step_cnt + 32'h1;
					end
				end
				PIN_WAIT_CLEAR: begin
					if (!int_alarm) begin
						pin_state <= PIN_IDLE;
					end
				end
				default: pin_state <= PIN_IDLE;
			endcase
		end
	end

	// Driver shutdown latch for mode 1, cleared only by power-on reset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			drv_latched_off <= 1'b0;
		end else if (|(all_events & shutdown_mask[6:0]) && react_cfg[`POS_REACT_MODE]) begin
			drv_latched_off <= 1'b1;
		end
	end

	// Pin and driver outputs
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_pin_out <= 1'b0;
			alarm_pin_oe_out <= 1'b0;
			alarm_pullup_out <= 1'b0;
			driver_enable_out <= 1'b0;
			aux_low_range_out <= 1'b1;
		end else begin
			alarm_pin_out <= 1'b0; // Open drain only pulls low
			alarm_pin_oe_out <= next_pin_oe;
			alarm_pullup_out <= pullup_cfg[`POS_PULLUP] && !drv_off;
			driver_enable_out <= !drv_off;
			aux_low_range_out <= drv_off;
		end
	end

	// Fault records; software writes are allowed but hardware set wins
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rec60 <= `RST_BYTE;
			rec61 <= `RST_BYTE;
			rec62 <= `RST_BYTE;
			rec63 <= `RST_BYTE;
			first_done <= 1'b0;
			prev_events <= 7'h00;
		end else begin
			prev_events <= logged;
			if (wr_ok && idx == `IDX_FIRST_REC) rec60 <= wb;
			if (wr_ok && idx == `IDX_LAST_REC_LOW) rec61 <= wb;
			if (wr_ok && idx == `IDX_LAST_CUM_REC) rec62 <= wb;
			if (wr_ok && idx == `IDX_CUM_REC_HIGH) rec63 <= wb;
			if (new_logged != 7'h0) begin
				if (!first_done) begin
					rec60 <= {1'b0, new_logged};
					first_done <= 1'b1;
				end
				rec61 <= {new_logged[5:0], rec61[1:0]};
				rec62 <= {rec62[7:4] | new_logged[3:0], rec62[3:1], new_logged[6]};
				rec63 <= {rec63[7:3], rec63[2:0] | new_logged[6:4]};
			end
		end
	end

	// Interrupt status: sticky, write one to clear, set wins
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_status <= 7'h00;
			irq_out <= 1'b0;
			prev_all <= 7'h00;
		end else begin
			// Edges of every event, not only logged ones, so a held event sets its bit once
			prev_all <= all_events;
			irq_status <= (irq_status & ~((wr_ok && idx == `IDX_IRQ_STATUS) ? wb[6:0] : 7'h00)) |
				(all_events & ~prev_all);
			irq_out <= |(irq_status & irq_mask);
		end
	end
endmodule : alarm_fault_log
`default_nettype wire

/* pkg/alarm_map.svh */
// Register offsets, field positions, reset values and timing counts for the alarm/fault logging block.
// Assumes an APB slave with one aligned 32-bit word per register; printed offsets are indices.
`ifndef ALARM_MAP_SVH
`define ALARM_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_ALARM_PIN_CFG 8'h55
`define IDX_ALARM_MASK 8'h54
`define IDX_SHUTDOWN_MASK 8'h56
`define IDX_PULLUP_CFG 8'h57
`define IDX_REACT_CFG 8'h58
`define IDX_FIRST_REC 8'h60
`define IDX_LAST_REC_LOW 8'h61
`define IDX_LAST_CUM_REC 8'h62
`define IDX_CUM_REC_HIGH 8'h63
`define IDX_EVENT_IN 8'h70
`define IDX_IRQ_STATUS 8'h71
`define IDX_IRQ_MASK 8'h72
`define IDX_TEMP_CTRL 8'h73
`define IDX_STATUS 8'h74

// Field positions
`define POS_POLARITY 2
`define POS_MIT_LO 3
`define POS_MIT_HI 5
`define POS_PULLUP 2
`define POS_REACT_MODE 6

// Event bit numbering
`define EV_CONFIG 6
`define EV_OVERTEMP 5
`define EV_EXTERNAL 4
`define EV_CTRL_MAX 3
`define EV_CTRL_MIN 2
`define EV_CLIP 1
`define EV_LOSS 0
`define NUM_EVENTS 7

// Reset values
`define RST_BYTE 8'h00
`define RST_TEMP_HYST 8'h05

// Timing: one indication step is 12.5 ms = 12500 us
`define MIT_STEP_US 12500
`define CLK_MHZ 125

`endif

/* pkg/alarm_pkg.sv */
// Types shared by the alarm output and fault logging block.
// Assumes nothing beyond a SystemVerilog compiler.
package alarm_pkg;
	typedef enum logic [1:0] {
		PIN_IDLE,
		PIN_HOLD,
		PIN_WAIT_CLEAR
	} pin_state_t;
	typedef logic [6:0] event_vec_t;
endpackage : alarm_pkg

/* testbench/alarm_wire_model.sv */
// Far side of the alarm pin: open-drain wire with a system pull-up and an outside error source.
// Assumes the block's pad output, output enable and one testbench control for the outside party.
`timescale 1ns/1ps
`default_nettype none
module alarm_wire_model (
	input wire logic pin_in,
	input wire logic oe_in,
	input wire logic ext_low_in,
	output logic level_out
);
	// Wire is low if either party pulls it; the system resistor lifts it otherwise
	assign level_out = !((oe_in && !pin_in) || ext_low_in);
endmodule : alarm_wire_model
`default_nettype wire

/* testbench/alarm_fault_log_sva.sv */
// Checker for the alarm block: bus answer timing, pin drive and shutdown.
// Assumes it is bound to every alarm_fault_log instance and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module alarm_fault_log_sva (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [7:0] temp_in,
	input wire logic alarm_pin_out,
	input wire logic alarm_pin_oe_out,
	input wire logic driver_enable_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// Bus answers exactly one cycle after setup, as a single pulse
	property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_pulse; pready_out |=> !pready_out; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_idle; !psel_in |=> !pready_out; endproperty
	a_idle: assert property (p_idle) else $error("ready without select");
	property p_misal;
		psel_in && !penable_in && paddr_in[1:0] != 2'b00 |=> pslverr_out && prdata_out == 32'h0000_0000;
	endproperty
	a_misal: assert property (p_misal) else $error("misaligned access accepted");
	// Records are bytes, so the upper read lanes stay clear
	property p_upper; pready_out |-> prdata_out[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	// Open drain: the pad may only ever pull low
	property p_pin_low; alarm_pin_out == 1'b0; endproperty
	a_pin_low: assert property (p_pin_low) else $error("pin driven high");
	// Over the shutdown level the drivers go off whatever the masks say
	property p_hot_off; temp_in > 8'h78 |-> ##[1:3] !driver_enable_out; endproperty
	a_hot_off: assert property (p_hot_off) else $error("drivers on when hot");
	// A settled shutdown also releases the pin
	property p_off_rel; !driver_enable_out && $past(!driver_enable_out) |-> !alarm_pin_oe_out; endproperty
	a_off_rel: assert property (p_off_rel) else $error("pin pulled in shutdown");
endmodule : alarm_fault_log_sva
bind alarm_fault_log alarm_fault_log_sva u_alarm_fault_log_sva (
	.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .temp_in(temp_in), .alarm_pin_out(alarm_pin_out),
	.alarm_pin_oe_out(alarm_pin_oe_out), .driver_enable_out(driver_enable_out));
`default_nettype wire

/* testbench/alarm_fault_log_tb_top.sv */
// Testbench for the alarm block: register access over the bus, pin, temperature and records.
// Assumes the wire model beside it and a short indication step of ten cycles.
`timescale 1ns/1ps
`default_nettype none
module alarm_fault_log_tb_top;
	import alarm_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic ext_low = 1'b0;
	logic [1:0] lo = 2'b00;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	event_vec_t ev = 7'h00;
	logic [7:0] temp = 8'h40;
	logic [31:0] prdata, rd;
	logic rdy, serr, se, lvl, pin_o, oe, pu, drv, aux, irq;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] ids [3] = '{8'h55, 8'h57, 8'h58};
	always #4 mclk_in = ~mclk_in;
	alarm_fault_log #(.STEP_CYCLES(10)) u_alarm_fault_log (.mclk_in(mclk_in), .rst_in(rst_in),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(rdy), .pslverr_out(serr), .event_in(ev), .temp_in(temp),
		.alarm_pin_in(lvl), .alarm_pin_out(pin_o), .alarm_pin_oe_out(oe), .alarm_pullup_out(pu),
		.driver_enable_out(drv), .aux_low_range_out(aux), .irq_out(irq));
	alarm_wire_model u_alarm_wire_model (.pin_in(pin_o), .oe_in(oe), .ext_low_in(ext_low), .level_out(lvl));
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	// Cuts a hang short well past the expected run length
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One bus transfer; request held until ready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk_in);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {22'h00_0000, idx, lo};
		pwdata <= {24'h00_0000, d};
		@(posedge mclk_in);
		pen <= 1'b1;
		do @(posedge mclk_in); while (rdy !== 1'b1);
		rd = prdata;
		se = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : xfer
	task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask : rc
	task automatic pulse(input logic [6:0] e);
		@(posedge mclk_in);
		ev <= e;
		@(posedge mclk_in);
		ev <= 7'h00;
		repeat (15) @(posedge mclk_in);
	endtask : pulse
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_in);
	endtask : wt
	// Main sequence; every wait below is a fixed settle or hold figure
	initial begin
		wt(4);
		rst_in <= 1'b0;
		foreach (ids[i]) begin
			rc(ids[i], 32'h0000_0000);
			xfer(1'b1, ids[i], 8'h3C);
			rc(ids[i], 32'h0000_003C);
			xfer(1'b1, ids[i], 8'h00);
		end
		rc(8'h10, 32'h0000_0000);
		chk(se, 1'b1);
		lo <= 2'b01;
		rc(8'h55, 32'h0000_0000);
		lo <= 2'b00;
		xfer(1'b1, 8'h57, 8'h34);
		wt(2);
		chk(pu, 1'b1);
		xfer(1'b1, 8'h54, 8'h23);
		xfer(1'b1, 8'h55, 8'h10);
		pulse(7'h01);
		chk(oe, 1'b1);
		wt(15);
		chk(oe, 1'b0);
		pulse(7'h02);
		wt(15);
		pulse(7'h04);
		chk(oe, 1'b0);
		rc(8'h60, 32'h0000_0001);
		rc(8'h61, 32'h0000_0008);
		rc(8'h62, 32'h0000_0030);
		rc(8'h63, 32'h0000_0000);
		xfer(1'b1, 8'h55, 8'h04);
		wt(3);
		chk(oe, 1'b1);
		xfer(1'b1, 8'h55, 8'h00);
		// Outside low raises the interrupt, which masks and clears
		xfer(1'b1, 8'h72, 8'h10);
		ext_low <= 1'b1;
		wt(6);
		chk(irq, 1'b1);
		xfer(1'b1, 8'h72, 8'h00);
		wt(2);
		chk(irq, 1'b0);
		ext_low <= 1'b0;
		xfer(1'b1, 8'h71, 8'h10);
		xfer(1'b1, 8'h72, 8'h10);
		wt(2);
		chk(irq, 1'b0);
		temp <= 8'h65;
		wt(3);
		chk(oe, 1'b1);
		temp <= 8'h60;
		wt(25);
		chk(oe, 1'b1);
		temp <= 8'h5E;
		wt(25);
		chk(oe, 1'b0);
		temp <= 8'h79;
		wt(3);
		chk(drv, 1'b0);
		temp <= 8'h40;
		wt(25);
		chk(drv, 1'b1);
		// Mode one keeps drivers off for good, so it runs last
		xfer(1'b1, 8'h56, 8'h04);
		xfer(1'b1, 8'h58, 8'h40);
		pulse(7'h04);
		wt(15);
		chk(drv, 1'b0);
		chk(aux, 1'b1);
		tally_and_finish();
	end
endmodule : alarm_fault_log_tb_top
`default_nettype wire
